// ==== smc_checker_asserts.sv ====
// Checker for the supply monitor control block, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module smc_checker
  import smc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port and fuse
  input wire logic [7:0] detectorFuseByte,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Power state and outputs
  input wire logic deepSleep,
  input wire logic debugHalt,
  input wire logic detectorEnable,
  input wire logic [2:0] dropThresholdCode,
  input wire logic [1:0] warningOffsetLevel,
  input wire logic warningIrq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  logic [1:0] upCnt_q;
  logic clrFlag;
  logic clrIe;
  assign clrFlag = regWrite && regAddr == SMC_ADDR_IRQFLG && regWrData[0];
  assign clrIe = regWrite && regAddr == SMC_ADDR_IRQCTL && !regWrData[0];
  // Fuse capture lands on the first edge after release, so the fuse-based checks (a_code, a_active, a_on) skip the first three cycles
  always_ff @(posedge clock)
  begin
    if (reset)
      upCnt_q <= 2'h0;
    else if (upCnt_q != 2'h3)
      upCnt_q <= upCnt_q + 2'h1;
  end
  property p_code; upCnt_q == 2'h3 |-> dropThresholdCode == detectorFuseByte[7:5]; endproperty
  a_code: assert property (p_code) else $error("threshold code off fuse");
  property p_active; upCnt_q == 2'h3 && regRead && regAddr == SMC_ADDR_MODE
    |=> regRdData[3:2] == detectorFuseByte[3:2]; endproperty
  a_active: assert property (p_active) else $error("active field changed");
  property p_halt; debugHalt |=> !warningIrq; endproperty
  a_halt: assert property (p_halt) else $error("request while halted");
  property p_hold; warningIrq && !debugHalt && !clrFlag && !clrIe |=> warningIrq;
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_ieoff; clrIe |=> ##1 !warningIrq; endproperty
  a_ieoff: assert property (p_ieoff) else $error("request with enable off");
  property p_clr; clrFlag |-> ##2 !warningIrq; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_on; (upCnt_q == 2'h3 && !deepSleep && detectorFuseByte[3:2] == SMC_MODE_ON)[*6]
    |-> detectorEnable; endproperty
  a_on: assert property (p_on) else $error("detector off in active mode");
  property p_lvl; regWrite && regAddr == SMC_ADDR_WLEVEL
    |-> ##2 warningOffsetLevel == $past(regWrData[1:0], 2); endproperty
  a_lvl: assert property (p_lvl) else $error("level output stale");
  c_halt: cover property (debugHalt && warningIrq);
  c_sleep: cover property ($rose(deepSleep));
  c_clear: cover property (clrFlag && warningIrq);
endmodule // smc_checker

bind smc_supply_monitor_control smc_checker checker_u (.clock, .reset, .detectorFuseByte,
  .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .deepSleep, .debugHalt,
  .detectorEnable, .dropThresholdCode, .warningOffsetLevel, .warningIrq);

// ==== smc_pkg.sv ====
// Package for the supply monitor control block: register map, field layout, codes, timing.
// Assumes a 40 MHz system clock and byte-wide registers on a plain strobe port.
package smc_pkg;
  // Register offsets (byte addresses)
  localparam logic [3:0] SMC_ADDR_MODE = 4'h0;
  localparam logic [3:0] SMC_ADDR_THRESH = 4'h1;
  localparam logic [3:0] SMC_ADDR_WLEVEL = 4'h8;
  localparam logic [3:0] SMC_ADDR_IRQCTL = 4'h9;
  localparam logic [3:0] SMC_ADDR_IRQFLG = 4'ha;
  localparam logic [3:0] SMC_ADDR_STATE = 4'hb;
  // Mode control field positions
  localparam int SMC_SLEEP_LSB = 0;
  localparam int SMC_ACTIVE_LSB = 2;
  localparam int SMC_RATE_BIT = 4;
  // Fuse byte layout
  localparam int SMC_FUSE_SLEEP_LSB = 0;
  localparam int SMC_FUSE_ACTIVE_LSB = 2;
  localparam int SMC_FUSE_RATE_BIT = 4;
  localparam int SMC_FUSE_LEVEL_LSB = 5;
  // Interrupt control layout
  localparam int SMC_IE_BIT = 0;
  localparam int SMC_DIR_LSB = 1;
  // Reset values
  localparam logic [7:0] SMC_BYTE_ZERO = 8'h00;
  localparam logic [1:0] SMC_TWO_ZERO = 2'h0;
  // Detector modes
  localparam logic [1:0] SMC_MODE_OFF = 2'h0;
  localparam logic [1:0] SMC_MODE_ON = 2'h1;
  localparam logic [1:0] SMC_MODE_SAMPLED = 2'h2;
  localparam logic [1:0] SMC_MODE_ON_WAIT = 2'h3;
  // Crossing directions
  localparam logic [1:0] SMC_DIR_FALL = 2'h0;
  localparam logic [1:0] SMC_DIR_RISE = 2'h1;
  localparam logic [1:0] SMC_DIR_BOTH = 2'h2;
  // Unlock key and window
  localparam logic [7:0] SMC_UNLOCK_KEY = 8'hd8;
  localparam int SMC_UNLOCK_INSTR = 4;
  localparam int SMC_CYCLES_PER_INSTR = 1;
  localparam logic [3:0] SMC_UNLOCK_CYCLES = 4'(SMC_UNLOCK_INSTR * SMC_CYCLES_PER_INSTR);
  // Timing
  localparam int SMC_CLOCK_HZ = 40000000;
  localparam int SMC_RATE_FAST_HZ = 1000;
  localparam int SMC_RATE_SLOW_HZ = 125;
  localparam int SMC_FAST_CYCLES = SMC_CLOCK_HZ / SMC_RATE_FAST_HZ;
  localparam int SMC_SLOW_CYCLES = SMC_CLOCK_HZ / SMC_RATE_SLOW_HZ;
  localparam int SMC_PULSE_NS = 100;
  localparam int SMC_PULSE_CYCLES = (SMC_PULSE_NS * (SMC_CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int SMC_TIMER_W = 19;
endpackage

// ==== smc_supply_monitor_control.sv ====
// Supply monitor control: detector mode, warning monitor, flag and register file.
// Assumes analog comparator outputs arrive asynchronously, power state comes from the
// sleep controller on the same clock, and the unlock key write comes from the CPU.
//
// Contract
// - Reset loads threshold, sample rate and both mode fields from fuse.
// - Active-mode field is read-only to software.
// - Interrupt control bit 0 enables or disables the warning interrupt.
// - Direction 0 fall, 1 rise, 2 either; others reserved.
// - Warning monitor off when detector off; sampled when detector sampled.
// - Enabling the interrupt with direction 2 sets the flag at once. The code sets it only while the detector is on.
// - Warning interrupt is not requested while the processor is debug-halted.
// - Request asserted while flag and enable set, held until flag cleared.
// - Sleep entry uses sleep-mode field; wake-up returns to active-mode field.
// - Protected writes accepted only within four instructions after the unlock key.
// - Protected writes without unlock are ignored, value unchanged.
// - Mode control bit 4 picks sample rate: 0 gives 1 kHz, 1 gives 125 Hz.
// - Active mode: 0 off, 1 on, 2 sampled, 3 on with wake held till ready.
// - Sleep mode: 0 off, 1 on, 2 sampled, 3 reserved; deep sleep only.
// - Threshold register exposes read-only three-bit fuse threshold code.
// - Warning level code 0,1,2 gives 5, 15, 25 percent above threshold.
// - Warning flag updated only while the detector is enabled.
// - Status bit reads 1 below warning level, 0 above; valid when enabled.
// - Sampled mode pulses the detector each period; enabled keeps it on.
`timescale 1ns/10ps
module smc_supply_monitor_control
  import smc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Configuration fuse
  input wire logic [7:0] detectorFuseByte,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Unlock key write from the processor protection register
  input wire logic registerUnlockKeyWrite,
  input wire logic [7:0] registerUnlockKey,
  input wire logic instrRetire,
  // Power state and debug
  input wire logic deepSleep,
  input wire logic debugHalt,
  // Analog side
  input wire logic belowWarningAsync,
  input wire logic detectorReadyAsync,
  output logic detectorEnable,
  output logic [2:0] dropThresholdCode,
  output logic [1:0] warningOffsetLevel,
  output logic wakeHold,
  // Interrupt request
  output logic warningIrq
);
  typedef enum logic [1:0] {
    SMC_ST_ACTIVE = 2'b00,
    SMC_ST_SLEEP = 2'b01,
    SMC_ST_WAKE = 2'b11
  } smc_pwr_t;

  typedef struct packed {
    logic fuseDone;
    logic [1:0] sleepMode;
    logic [1:0] activeMode;
    logic sampleRateSelect;
    logic [2:0] dropCode;
    logic [1:0] offsetLevel;
    logic warningIrqEnable;
    logic [1:0] crossingDirection;
    logic warningFlag;
    logic belowState;
    logic belowPrev;
    logic prevValid;
    logic [3:0] unlockLeft;
    logic [SMC_TIMER_W-1:0] sampleTimer;
    logic [3:0] pulseLeft;
    smc_pwr_t pwr;
    logic detEn;
    logic wakeHoldOut;
    logic irq;
    logic [7:0] rdData;
  } smc_state_t;

  smc_state_t state_q, state_d;
  logic belowSync;
  logic readySync;
  logic [1:0] modeNow;
  logic detOn;
  logic sampleTick;
  logic [SMC_TIMER_W-1:0] periodCycles;
  logic fell;
  logic rose;
  logic trigger;
  logic protWrite;

  smc_sync uBelowSync (
    .clock(clock),
    .reset(reset),
    .async(belowWarningAsync),
    .synced(belowSync)
  );

  smc_sync uReadySync (
    .clock(clock),
    .reset(reset),
    .async(detectorReadyAsync),
    .synced(readySync)
  );

  always_comb
  begin
    state_d = state_q;
    // Fuse values are captured on the first clock after reset release
    if (!state_q.fuseDone)
    begin
      state_d.fuseDone = 1'b1;
      state_d.sleepMode = detectorFuseByte[SMC_FUSE_SLEEP_LSB +: 2];
      state_d.activeMode = detectorFuseByte[SMC_FUSE_ACTIVE_LSB +: 2];
      state_d.sampleRateSelect = detectorFuseByte[SMC_FUSE_RATE_BIT];
      state_d.dropCode = detectorFuseByte[SMC_FUSE_LEVEL_LSB +: 3];
    end

    // Power state sequencing
    unique case (state_q.pwr)
      SMC_ST_ACTIVE:
        if (deepSleep)
          state_d.pwr = SMC_ST_SLEEP;
      SMC_ST_SLEEP:
        if (!deepSleep)
          state_d.pwr = SMC_ST_WAKE;
      SMC_ST_WAKE:
        state_d.pwr = SMC_ST_ACTIVE;
      default:
        state_d.pwr = SMC_ST_ACTIVE;
    endcase

    // Mode in force; reserved sleep code 3 is treated as off
    if (state_q.pwr == SMC_ST_SLEEP)
      modeNow = (state_q.sleepMode == SMC_MODE_ON_WAIT) ? SMC_MODE_OFF : state_q.sleepMode;
    else
      modeNow = state_q.activeMode;

    // Sample period timer
    periodCycles = state_q.sampleRateSelect ? SMC_TIMER_W'(SMC_SLOW_CYCLES)
                                            : SMC_TIMER_W'(SMC_FAST_CYCLES);
    sampleTick = (state_q.sampleTimer >= periodCycles - SMC_TIMER_W'(1));
    if (modeNow != SMC_MODE_SAMPLED || sampleTick)
      state_d.sampleTimer = '0;
    else
      state_d.sampleTimer = state_q.sampleTimer + SMC_TIMER_W'(1);
    if (modeNow == SMC_MODE_SAMPLED && sampleTick)
      state_d.pulseLeft = 4'(SMC_PULSE_CYCLES);
    else if (state_q.pulseLeft != 4'h0)
      state_d.pulseLeft = state_q.pulseLeft - 4'h1;

    detOn = (modeNow == SMC_MODE_ON) || (modeNow == SMC_MODE_ON_WAIT)
         || (modeNow == SMC_MODE_SAMPLED && state_q.pulseLeft != 4'h0);
    state_d.detEn = detOn;
    // Wake-up waits for the detector when active code 3 is in force
    state_d.wakeHoldOut = (state_q.pwr == SMC_ST_WAKE || state_q.wakeHoldOut)
                        && state_q.activeMode == SMC_MODE_ON_WAIT && !readySync;

    // Warning monitor runs only while the detector is sampling the supply
    fell = state_q.prevValid && belowSync && !state_q.belowPrev;
    rose = state_q.prevValid && !belowSync && state_q.belowPrev;
    unique case (state_q.crossingDirection)
      SMC_DIR_FALL: trigger = fell;
      SMC_DIR_RISE: trigger = rose;
      SMC_DIR_BOTH: trigger = fell || rose;
      default: trigger = 1'b0;
    endcase
    if (detOn)
    begin
      state_d.belowState = belowSync;
      state_d.belowPrev = belowSync;
      state_d.prevValid = 1'b1;
    end

    // Unlock window counts retired instructions
    if (registerUnlockKeyWrite && registerUnlockKey == SMC_UNLOCK_KEY)
      state_d.unlockLeft = SMC_UNLOCK_CYCLES;
    else if (instrRetire && state_q.unlockLeft != 4'h0)
      state_d.unlockLeft = state_q.unlockLeft - 4'h1;
    protWrite = state_q.unlockLeft != 4'h0;

    // Register writes
    if (regWrite)
    begin
      unique case (regAddr)
        SMC_ADDR_MODE:
          if (protWrite)
          begin
            state_d.sleepMode = regWrData[SMC_SLEEP_LSB +: 2];
            state_d.sampleRateSelect = regWrData[SMC_RATE_BIT];
            state_d.unlockLeft = 4'h0;
          end
        SMC_ADDR_WLEVEL:
          state_d.offsetLevel = regWrData[1:0];
        SMC_ADDR_IRQCTL:
        begin
          state_d.warningIrqEnable = regWrData[SMC_IE_BIT];
          state_d.crossingDirection = regWrData[SMC_DIR_LSB +: 2];
        end
        default:
          ;
      endcase
    end

    // Flag: clear by writing one, but a new event in the same cycle wins
    if (regWrite && regAddr == SMC_ADDR_IRQFLG && regWrData[0])
      state_d.warningFlag = 1'b0;
    if (detOn && trigger)
      state_d.warningFlag = 1'b1;
    // Enabling with either-direction sets the flag immediately, but only while the detector is on
    if (regWrite && regAddr == SMC_ADDR_IRQCTL && regWrData[SMC_IE_BIT]
        && !state_q.warningIrqEnable && regWrData[SMC_DIR_LSB +: 2] == SMC_DIR_BOTH
        && detOn)
      state_d.warningFlag = 1'b1;

    state_d.irq = state_d.warningFlag && state_d.warningIrqEnable && !debugHalt;

    // Read data for the cycle after the strobe
    state_d.rdData = SMC_BYTE_ZERO;
    if (regRead)
    begin
      unique case (regAddr)
        SMC_ADDR_MODE:
          state_d.rdData = {3'h0, state_q.sampleRateSelect, state_q.activeMode,
                            state_q.sleepMode};
        SMC_ADDR_THRESH:
          state_d.rdData = {5'h0, state_q.dropCode};
        SMC_ADDR_WLEVEL:
          state_d.rdData = {6'h0, state_q.offsetLevel};
        SMC_ADDR_IRQCTL:
          state_d.rdData = {5'h0, state_q.crossingDirection, state_q.warningIrqEnable};
        SMC_ADDR_IRQFLG:
          state_d.rdData = {7'h0, state_q.warningFlag};
        SMC_ADDR_STATE:
          state_d.rdData = {7'h0, state_q.belowState};
        default:
          state_d.rdData = SMC_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= '0;
      state_q.pwr <= SMC_ST_ACTIVE;
      state_q.offsetLevel <= SMC_TWO_ZERO;
    end
    else
      state_q <= state_d;
  end

  assign regRdData = state_q.rdData;
  assign detectorEnable = state_q.detEn;
  assign dropThresholdCode = state_q.dropCode;
  assign warningOffsetLevel = state_q.offsetLevel;
  assign wakeHold = state_q.wakeHoldOut;
  assign warningIrq = state_q.irq;
endmodule // smc_supply_monitor_control

// ==== smc_supply_monitor_control_tb.sv ====
// Directed testbench for the supply monitor control block over its register port.
// Assumes the checker is bound in; fuse byte and ready level are held constant.
`timescale 1ns/10ps
module smc_supply_monitor_control_tb;
  import smc_pkg::*;
  localparam logic [7:0] FUSE = 8'ha6;
  logic clock, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, keyWrite = 1'b0;
  logic instrRetire = 1'b0, deepSleep = 1'b0, debugHalt = 1'b0, belowWarningAsync = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, key = 8'h00, regRdData;
  logic detectorEnable, wakeHold, warningIrq;
  logic [2:0] dropThresholdCode;
  logic [1:0] warningOffsetLevel;
  logic [1:0] dirTab [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2};
  logic newTab [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic expTab [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int error_cnt, checks_done, cycles, highs;
  smc_supply_monitor_control dut_u (.clock(clock), .reset(reset), .detectorFuseByte(FUSE),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .registerUnlockKeyWrite(keyWrite), .registerUnlockKey(key),
    .instrRetire(instrRetire), .deepSleep(deepSleep), .debugHalt(debugHalt),
    .belowWarningAsync(belowWarningAsync), .detectorReadyAsync(1'b1),
    .detectorEnable(detectorEnable), .dropThresholdCode(dropThresholdCode),
    .warningOffsetLevel(warningOffsetLevel), .wakeHold(wakeHold), .warningIrq(warningIrq));
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Ends just after an edge so registered outputs have settled
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(string what, logic [3:0] a, logic [7:0] exp);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    check(what, regRdData, exp);
  endtask
  task automatic unlock(int retires);
    @(posedge clock);
    keyWrite <= 1'b1;
    key <= SMC_UNLOCK_KEY;
    @(posedge clock);
    keyWrite <= 1'b0;
    // Only touch the retire pulse when one is wanted, so it is never assigned twice
    if (retires > 0)
    begin
      instrRetire <= 1'b1;
      repeat (retires) @(posedge clock);
      instrRetire <= 1'b0;
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    tick(3);
    rd("mode", SMC_ADDR_MODE, {3'h0, FUSE[4:0]});
    rd("thresh", SMC_ADDR_THRESH, {5'h0, FUSE[7:5]});
    check("code", {5'h0, dropThresholdCode}, {5'h0, FUSE[7:5]});
    rd("unmapped", 4'h5, 8'h00);
    wr(SMC_ADDR_WLEVEL, 8'h02);
    rd("level", SMC_ADDR_WLEVEL, 8'h02);
    check("level out", {6'h0, warningOffsetLevel}, 8'h02);
    wr(SMC_ADDR_MODE, 8'h12);
    rd("locked", SMC_ADDR_MODE, 8'h06);
    unlock(0);
    wr(SMC_ADDR_MODE, 8'h0c);
    rd("unlocked", SMC_ADDR_MODE, 8'h04);
    unlock(5);
    wr(SMC_ADDR_MODE, 8'h12);
    rd("late", SMC_ADDR_MODE, 8'h04);
    wr(SMC_ADDR_THRESH, 8'h00);
    rd("thresh ro", SMC_ADDR_THRESH, {5'h0, FUSE[7:5]});
    wr(SMC_ADDR_IRQCTL, 8'h05);
    tick(2);
    rd("flag now", SMC_ADDR_IRQFLG, 8'h01);
    check("irq", {7'h0, warningIrq}, 8'h01);
    @(posedge clock);
    debugHalt <= 1'b1;
    tick(2);
    check("irq halted", {7'h0, warningIrq}, 8'h00);
    @(posedge clock);
    debugHalt <= 1'b0;
    wr(SMC_ADDR_IRQFLG, 8'h00);
    tick(2);
    check("irq kept", {7'h0, warningIrq}, 8'h01);
    wr(SMC_ADDR_IRQCTL, 8'h04);
    tick(2);
    check("irq masked", {7'h0, warningIrq}, 8'h00);
    wr(SMC_ADDR_IRQCTL, 8'h05);
    tick(2);
    wr(SMC_ADDR_IRQFLG, 8'h01);
    tick(2);
    check("irq cleared", {7'h0, warningIrq}, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      wr(SMC_ADDR_IRQCTL, {5'h0, dirTab[i], 1'b1});
      wr(SMC_ADDR_IRQFLG, 8'h01);
      belowWarningAsync <= newTab[i];
      tick(6);
      rd("dir flag", SMC_ADDR_IRQFLG, {7'h0, expTab[i]});
      rd("status", SMC_ADDR_STATE, {7'h0, newTab[i]});
    end
    wr(SMC_ADDR_IRQCTL, 8'h05);
    wr(SMC_ADDR_IRQFLG, 8'h01);
    deepSleep <= 1'b1;
    tick(4);
    check("sleep off", {7'h0, detectorEnable}, 8'h00);
    @(posedge clock);
    belowWarningAsync <= 1'b0;
    tick(6);
    rd("flag held", SMC_ADDR_IRQFLG, 8'h00);
    rd("status held", SMC_ADDR_STATE, 8'h01);
    @(posedge clock);
    deepSleep <= 1'b0;
    tick(4);
    check("awake", {7'h0, detectorEnable}, 8'h01);
    check("no wake hold", {7'h0, wakeHold}, 8'h00);
    unlock(0);
    wr(SMC_ADDR_MODE, 8'h02);
    rd("sampled", SMC_ADDR_MODE, 8'h06);
    @(posedge clock);
    deepSleep <= 1'b1;
    tick(100);
    highs = 0;
    repeat (SMC_FAST_CYCLES)
    begin
      tick(1);
      highs += int'(detectorEnable);
    end
    check("pulse", 8'(highs), 8'(SMC_PULSE_CYCLES));
    unlock(0);
    wr(SMC_ADDR_MODE, 8'h12);
    rd("slow rate", SMC_ADDR_MODE, 8'h16);
    @(posedge clock);
    deepSleep <= 1'b0;
    wrap_up();
  end
endmodule // smc_supply_monitor_control_tb

// ==== smc_sync.sv ====
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slowly changing level, not a pulse.
`timescale 1ns/10ps
module smc_sync
  import smc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Level
  input wire logic async,
  output logic synced
);
  typedef struct packed {
    logic first;
    logic second;
  } smc_sync_t;
  smc_sync_t state_q, state_d;

  always_comb
  begin
    state_d.first = async;
    state_d.second = state_q.first;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign synced = state_q.second;
endmodule // smc_sync
